//--- pkg/msq_pkg.sv
// Shared constants, state encoding and pin bundle for the mode sequencer.
// Assumes one 40 MHz core clock; millisecond scale is a top-level parameter.
package msq_pkg;

    // ==========================================================
    // Clock and timing
    localparam int CLK_MHZ = 40;
    localparam int CLK_KHZ = 40000;
    localparam int TMR_W = 24;
    localparam int PH_W = 13;
    localparam int NREQ_TMO_MS = 350;
    localparam int UV_HOLD_MS = 100;
    localparam int RST_DUR_MS = 4;
    localparam int WAKE_DLY_US = 100;
    localparam int CAN_DLY_US = 80;
    localparam int SAMPLE_LEAD_US = 10;
    localparam int HS_ON_US = 100;
    localparam int INT_PULSE_US = 10;
    localparam int CMD_DLY_US = 33;
    localparam int WDOG_RST_US = 100;
    localparam int WAKE_DLY_CYC = WAKE_DLY_US * CLK_MHZ;
    localparam int CAN_DLY_CYC = CAN_DLY_US * CLK_MHZ;
    localparam int SAMPLE_LEAD_CYC = SAMPLE_LEAD_US * CLK_MHZ;
    localparam int HS_ON_CYC = HS_ON_US * CLK_MHZ;
    localparam int INT_PULSE_CYC = INT_PULSE_US * CLK_MHZ;
    localparam int CMD_DLY_CYC = CMD_DLY_US * CLK_MHZ;
    localparam int WDOG_RST_CYC = WDOG_RST_US * CLK_MHZ;

    // ==========================================================
    // Selection tables
    localparam int WDOG_MS [4] = '{10, 45, 100, 350};
    localparam int CYC_MS [8] = '{5, 10, 20, 40, 75, 100, 200, 400};
    localparam logic [1:0] CAN_LAST_IDX = 2'h2;

    // ==========================================================
    // Modes
    typedef enum logic [3:0] {
        ST_NREQ,
        ST_NORMAL,
        ST_WDOG_RST,
        ST_UV_RST,
        ST_UV_HOLD,
        ST_SLEEP,
        ST_SLP_WAKE,
        ST_SLP_RAMP,
        ST_SLP_RST,
        ST_STOP,
        ST_STP_WAKE,
        ST_STP_INT,
        ST_STP_SETTLE
    } msq_state_t;

    typedef struct packed {
        logic reset_n;
        logic int_n;
        logic watchdog_flag_pin_n;
        logic main_reg_en;
        logic tracking_reg_en;
        logic high_side_switch_en;
    } msq_pins_t;

    localparam msq_pins_t PINS_RST = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

endpackage : msq_pkg

//--- hw/msq_timer.sv
// Loadable down-counter with a one-cycle expiry pulse.
// Assumes a synchronous active-low reset copy from the parent.
`timescale 1ns/10ps
module msq_timer #(
    parameter int W = 24
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Control
    input wire logic load_in,
    input wire logic [W-1:0] value_in,
    // Expiry
    output logic done_out
);

    logic [W-1:0] cnt_q;
    logic done_q;

    // ==========================================================
    // Counter
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            cnt_q <= '0;
        else if (load_in)
            cnt_q <= value_in;
        else if (cnt_q != '0)
            cnt_q <= cnt_q - W'(1);
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            done_q <= 1'b0;
        else
            done_q <= !load_in && (cnt_q == W'(1));
    end

    assign done_out = done_q;

endmodule : msq_timer

//--- hw/msq_sequencer.sv
// Power mode sequencer: power-up, undervoltage reaction and wake-up.
// Assumes synchronous host strobes and comparator levels on core_clk_in.
`timescale 1ns/10ps
// Operation
// - Power-up enters normal-request, main regulator on, tracking regulator off.
// - Normal-request holds watchdog pin low; no timing write in 350 ms resets.
// - Timing write leaves normal-request: normal mode, tracking on, pin released.
// - Host keeps refreshing; a missed refresh resets and returns to normal-request.
// - Undervoltage with stop selected enters reset mode, reset and interrupt low.
// - After the stop undervoltage clears, restart in normal-request.
// - Undervoltage with sleep selected, flag clear: hold 100 ms, then sleep.
// - Sleep: wake input level turns main regulator on after 100 us.
// - Sleep wake-up: reset held at least 4.0 ms after regulator recovers.
// - Sleep: third valid CAN dominant pulse wakes, regulator on after 80 us.
// - Cyclic sense samples wake inputs 10 us before switch on-time ends.
// - Cyclic period follows the cyclic timing selection, 5 to 400 ms.
// - Stop wake-up gives an interrupt pulse, then a delay before commands.
// - Stop: wake input level gives interrupt pulse after 100 us.
// - Stop: interrupt pulse 80 us after the third CAN pulse.
// - Sleep wake-up ends with reset rising; host software may then start.
module msq_sequencer #(
    parameter int MS_CYC = msq_pkg::CLK_KHZ,
    parameter int NWAKE = 4
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    // Host commands
    input wire logic wdog_write_in,
    input wire logic [1:0] wdog_sel_in,
    input wire logic [2:0] cyc_sel_in,
    input wire logic cyc_sense_en_in,
    input wire logic lp_enter_in,
    input wire logic lp_sleep_sel_in,
    input wire logic supply_loss_flag_in,
    // Analog and bus status
    input wire logic main_reg_low_in,
    input wire logic [NWAKE-1:0] wake_input_in,
    input wire logic can_dominant_in,
    // Pins and status
    output msq_pkg::msq_pins_t pins_out,
    output logic cmd_ready_out,
    output msq_pkg::msq_state_t mode_out
);

    localparam int TW = msq_pkg::TMR_W;
    localparam int PW = msq_pkg::PH_W;

    logic [1:0] rst_sync_q;
    logic rst_n;
    msq_pkg::msq_state_t state_q, state_d;
    msq_pkg::msq_pins_t pins_q, pins_d;
    logic ready_q;
    logic [1:0] wdog_sel_q;
    logic [1:0] can_cnt_q;
    logic lp_q, lp_now, can_hit, wake_lvl, cyc_hit, wake_hit;
    logic tmr_load, tmr_done, cs_load, cs_done;
    logic [TW-1:0] tmr_val, cs_val;
    logic [PW-1:0] phase_q;
    logic uv_stop, uv_sleep;
    logic boot_q, via_can_q;
    logic [TW-1:0] dwell_q;

    // ==========================================================
    // Reset release
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end

    assign rst_n = rst_sync_q[1];

    // ==========================================================
    // Wake sources
    assign lp_now = (state_q == msq_pkg::ST_SLEEP) || (state_q == msq_pkg::ST_STOP);
    assign can_hit = lp_now && can_dominant_in && (can_cnt_q == msq_pkg::CAN_LAST_IDX);
    assign wake_lvl = |wake_input_in;
    assign cyc_hit = pins_q.high_side_switch_en && wake_lvl
        && (phase_q == PW'(msq_pkg::SAMPLE_LEAD_CYC));
    assign wake_hit = lp_now && (cyc_sense_en_in ? cyc_hit : wake_lvl);

    always_ff @(posedge core_clk_in or negedge rst_n)
    begin
        if (!rst_n)
            can_cnt_q <= 2'h0;
        else if (!lp_now)
            can_cnt_q <= 2'h0;
        else if (can_dominant_in)
            can_cnt_q <= can_cnt_q + 2'h1;
    end

    // ==========================================================
    // Undervoltage reaction
    assign uv_sleep = main_reg_low_in && lp_sleep_sel_in && !supply_loss_flag_in;
    assign uv_stop = main_reg_low_in && !uv_sleep;

    // ==========================================================
    // Mode transitions
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            msq_pkg::ST_NREQ, msq_pkg::ST_NORMAL, msq_pkg::ST_WDOG_RST,
            msq_pkg::ST_STOP, msq_pkg::ST_STP_WAKE, msq_pkg::ST_STP_INT,
            msq_pkg::ST_STP_SETTLE:
            begin
                if (uv_sleep)
                    state_d = msq_pkg::ST_UV_HOLD;
                else if (uv_stop)
                    state_d = msq_pkg::ST_UV_RST;
                else if (state_q == msq_pkg::ST_NREQ && wdog_write_in)
                    state_d = msq_pkg::ST_NORMAL;
                else if (state_q == msq_pkg::ST_NREQ && tmr_done)
                    state_d = msq_pkg::ST_WDOG_RST;
                else if (state_q == msq_pkg::ST_NORMAL && lp_enter_in)
                    state_d = lp_sleep_sel_in ? msq_pkg::ST_SLEEP : msq_pkg::ST_STOP;
                else if (state_q == msq_pkg::ST_NORMAL && tmr_done && !wdog_write_in)
                    state_d = msq_pkg::ST_WDOG_RST;
                else if (state_q == msq_pkg::ST_WDOG_RST && tmr_done)
                    state_d = msq_pkg::ST_NREQ;
                else if (state_q == msq_pkg::ST_STOP && (wake_hit || can_hit))
                    state_d = msq_pkg::ST_STP_WAKE;
                else if (state_q == msq_pkg::ST_STP_WAKE && tmr_done)
                    state_d = msq_pkg::ST_STP_INT;
                else if (state_q == msq_pkg::ST_STP_INT && tmr_done)
                    state_d = msq_pkg::ST_STP_SETTLE;
                else if (state_q == msq_pkg::ST_STP_SETTLE && tmr_done)
                    state_d = msq_pkg::ST_NORMAL;
            end
            msq_pkg::ST_UV_RST:
            begin
                if (!main_reg_low_in)
                    state_d = msq_pkg::ST_NREQ;
            end
            msq_pkg::ST_UV_HOLD:
            begin
                if (tmr_done)
                    state_d = msq_pkg::ST_SLEEP;
            end
            msq_pkg::ST_SLEEP:
            begin
                if (wake_hit || can_hit)
                    state_d = msq_pkg::ST_SLP_WAKE;
            end
            msq_pkg::ST_SLP_WAKE:
            begin
                if (tmr_done)
                    state_d = msq_pkg::ST_SLP_RAMP;
            end
            msq_pkg::ST_SLP_RAMP:
            begin
                if (!main_reg_low_in)
                    state_d = msq_pkg::ST_SLP_RST;
            end
            msq_pkg::ST_SLP_RST:
            begin
                if (tmr_done)
                    state_d = msq_pkg::ST_NREQ;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n)
    begin
        if (!rst_n)
            state_q <= msq_pkg::ST_NREQ;
        else
            state_q <= state_d;
    end

    always_ff @(posedge core_clk_in or negedge rst_n)
    begin
        if (!rst_n)
            wdog_sel_q <= 2'h3;
        else if (wdog_write_in)
            wdog_sel_q <= wdog_sel_in;
    end

    // ==========================================================
    // Mode timer
    always_ff @(posedge core_clk_in or negedge rst_n)
    begin
        if (!rst_n)
            boot_q <= 1'b1;
        else
            boot_q <= 1'b0;
    end

    assign tmr_load = boot_q || (state_d != state_q)
        || (state_q == msq_pkg::ST_NORMAL && wdog_write_in);

    always_comb
    begin
        tmr_val = '0;
        unique case (state_d)
            msq_pkg::ST_NREQ:
                tmr_val = TW'(msq_pkg::NREQ_TMO_MS * MS_CYC);
            msq_pkg::ST_NORMAL:
                tmr_val = TW'(msq_pkg::WDOG_MS[wdog_write_in ? wdog_sel_in : wdog_sel_q]
                    * MS_CYC);
            msq_pkg::ST_WDOG_RST:
                tmr_val = TW'(msq_pkg::WDOG_RST_CYC);
            msq_pkg::ST_UV_HOLD:
                tmr_val = TW'(msq_pkg::UV_HOLD_MS * MS_CYC);
            msq_pkg::ST_SLP_WAKE, msq_pkg::ST_STP_WAKE:
                tmr_val = can_hit ? TW'(msq_pkg::CAN_DLY_CYC)
                    : TW'(msq_pkg::WAKE_DLY_CYC);
            msq_pkg::ST_SLP_RST:
                tmr_val = TW'(msq_pkg::RST_DUR_MS * MS_CYC);
            msq_pkg::ST_STP_INT:
                tmr_val = TW'(msq_pkg::INT_PULSE_CYC);
            msq_pkg::ST_STP_SETTLE:
                tmr_val = TW'(msq_pkg::CMD_DLY_CYC);
            msq_pkg::ST_UV_RST, msq_pkg::ST_SLEEP, msq_pkg::ST_SLP_RAMP, msq_pkg::ST_STOP:
                tmr_val = '0;
        endcase
    end

    msq_timer #(
        .W(TW)
    ) u_mode_tmr (
        .clk_in(core_clk_in),
        .rst_n_in(rst_n),
        .load_in(tmr_load),
        .value_in(tmr_val),
        .done_out(tmr_done)
    );

    // ==========================================================
    // Cyclic sense
    assign cs_load = lp_now && cyc_sense_en_in && (!lp_q || cs_done);
    assign cs_val = TW'(msq_pkg::CYC_MS[cyc_sel_in] * MS_CYC);

    msq_timer #(
        .W(TW)
    ) u_cyc_tmr (
        .clk_in(core_clk_in),
        .rst_n_in(rst_n),
        .load_in(cs_load),
        .value_in(cs_val),
        .done_out(cs_done)
    );

    always_ff @(posedge core_clk_in or negedge rst_n)
    begin
        if (!rst_n)
            lp_q <= 1'b0;
        else
            lp_q <= lp_now;
    end

    always_ff @(posedge core_clk_in or negedge rst_n)
    begin
        if (!rst_n)
            phase_q <= '0;
        else if (cs_load)
            phase_q <= PW'(msq_pkg::HS_ON_CYC);
        else if (phase_q != '0)
            phase_q <= phase_q - PW'(1);
    end

    // ==========================================================
    // Pin drive
    always_comb
    begin
        pins_d = msq_pkg::PINS_RST;
        pins_d.reset_n = !(state_d inside {msq_pkg::ST_WDOG_RST, msq_pkg::ST_UV_RST,
            msq_pkg::ST_UV_HOLD, msq_pkg::ST_SLEEP, msq_pkg::ST_SLP_WAKE,
            msq_pkg::ST_SLP_RAMP, msq_pkg::ST_SLP_RST});
        pins_d.int_n = !(state_d inside {msq_pkg::ST_UV_RST, msq_pkg::ST_UV_HOLD,
            msq_pkg::ST_STP_INT});
        pins_d.watchdog_flag_pin_n = !(state_d inside {msq_pkg::ST_NREQ,
            msq_pkg::ST_WDOG_RST});
        pins_d.main_reg_en = !(state_d inside {msq_pkg::ST_SLEEP,
            msq_pkg::ST_SLP_WAKE});
        pins_d.tracking_reg_en = (state_d == msq_pkg::ST_NORMAL);
        pins_d.high_side_switch_en = lp_now && cyc_sense_en_in
            && (cs_load || phase_q > PW'(1));
    end

    always_ff @(posedge core_clk_in or negedge rst_n)
    begin
        if (!rst_n)
            pins_q <= msq_pkg::PINS_RST;
        else
            pins_q <= pins_d;
    end

    always_ff @(posedge core_clk_in or negedge rst_n)
    begin
        if (!rst_n)
            ready_q <= 1'b0;
        else
            ready_q <= (state_d == msq_pkg::ST_NREQ) || (state_d == msq_pkg::ST_NORMAL);
    end

    assign pins_out = pins_q;
    assign cmd_ready_out = ready_q;
    assign mode_out = state_q;

    // ==========================================================
    // Checks
    // Cycles spent in the current mode
    always_ff @(posedge core_clk_in or negedge rst_n)
    begin
        if (!rst_n)
            dwell_q <= '0;
        else if (state_d != state_q)
            dwell_q <= '0;
        else
            dwell_q <= dwell_q + TW'(1);
    end

    // Wake source of the last low-power exit
    always_ff @(posedge core_clk_in or negedge rst_n)
    begin
        if (!rst_n)
            via_can_q <= 1'b0;
        else if (lp_now && state_d != state_q)
            via_can_q <= can_hit;
    end

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n);

    sequence s_wdog_rst;
        state_q == msq_pkg::ST_WDOG_RST && !pins_q.reset_n;
    endsequence

    sequence s_nreq_back;
        ##1 state_q == msq_pkg::ST_NREQ && pins_q.reset_n;
    endsequence

    nreq_pin_low_a: assert property (
        state_q == msq_pkg::ST_NREQ |-> !pins_q.watchdog_flag_pin_n && !pins_q.tracking_reg_en)
        else $error("normal-request pins wrong");

    nreq_timeout_a: assert property (
        state_q == msq_pkg::ST_NREQ && tmr_done && !main_reg_low_in && !wdog_write_in
        |=> s_wdog_rst ##0 dwell_q == TW'(0))
        else $error("normal-request timeout not handled");

    normal_entry_a: assert property (
        state_q == msq_pkg::ST_NREQ && wdog_write_in && !main_reg_low_in
        |=> state_q == msq_pkg::ST_NORMAL && pins_q.tracking_reg_en
            && pins_q.watchdog_flag_pin_n && pins_q.reset_n)
        else $error("normal mode entry wrong");

    wdog_miss_a: assert property (
        state_q == msq_pkg::ST_NORMAL && tmr_done && !main_reg_low_in
            && !wdog_write_in && !lp_enter_in
        |=> s_wdog_rst ##0 dwell_q == TW'(0))
        else $error("missed refresh not reset");

    wdog_rst_len_a: assert property (
        state_q == msq_pkg::ST_WDOG_RST && tmr_done && !main_reg_low_in
        |-> dwell_q == TW'(msq_pkg::WDOG_RST_CYC) ##0 s_nreq_back)
        else $error("watchdog reset length wrong");

    stop_uv_a: assert property (
        state_q == msq_pkg::ST_NORMAL && main_reg_low_in && !lp_sleep_sel_in
        |=> state_q == msq_pkg::ST_UV_RST && !pins_q.reset_n && !pins_q.int_n)
        else $error("stop undervoltage not reset");

    uv_restart_a: assert property (
        state_q == msq_pkg::ST_UV_RST && !main_reg_low_in |=> state_q == msq_pkg::ST_NREQ)
        else $error("no restart after undervoltage");

    sleep_hold_a: assert property (
        state_q == msq_pkg::ST_UV_HOLD && tmr_done
        |-> !pins_q.reset_n && !pins_q.int_n
            ##1 state_q == msq_pkg::ST_SLEEP && !pins_q.main_reg_en && !pins_q.tracking_reg_en)
        else $error("sleep undervoltage hold wrong");

    sleep_wake_a: assert property (
        state_q == msq_pkg::ST_SLP_WAKE && tmr_done && !via_can_q
        |-> !pins_q.main_reg_en && dwell_q == TW'(msq_pkg::WAKE_DLY_CYC)
            ##1 pins_q.main_reg_en)
        else $error("sleep wake delay wrong");

    can_wake_a: assert property (
        state_q == msq_pkg::ST_SLP_WAKE && tmr_done && via_can_q
        |-> !pins_q.main_reg_en && dwell_q == TW'(msq_pkg::CAN_DLY_CYC)
            ##1 pins_q.main_reg_en)
        else $error("CAN wake delay wrong");

    wake_release_a: assert property (
        state_q == msq_pkg::ST_SLP_RST && tmr_done |=> $rose(pins_q.reset_n))
        else $error("reset not released after wake");

    stop_int_a: assert property (
        state_q == msq_pkg::ST_STP_WAKE && tmr_done && !main_reg_low_in
        |=> !pins_q.int_n [*8] ##[392:395] pins_q.int_n && !ready_q)
        else $error("stop interrupt pulse wrong");

endmodule : msq_sequencer

//--- sim/msq_host_model.sv
// Host model: pulses watchdog timing writes while enabled.
// Assumes the core clock and the reset pin of the sequencer.
`timescale 1ns/10ps
module msq_host_model (
    // Clock and pin
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Bench control
    input wire logic en_in,
    input wire logic [1:0] sel_in,
    input wire logic [7:0] gap_in,
    // Write strobe
    output logic wdog_write_out,
    output logic [1:0] wdog_sel_out
);
    // ==========================================================
    // Refresh loop
    logic [7:0] cnt_q;
    initial
    begin
        wdog_write_out = 1'b0;
        wdog_sel_out = 2'h0;
        cnt_q = 8'h00;
    end
    always @(negedge clk_in)
    begin
        if (en_in && reset_n_in && cnt_q >= gap_in)
        begin
            wdog_write_out <= 1'b1;
            wdog_sel_out <= sel_in;
            cnt_q <= 8'h00;
        end
        else
        begin
            wdog_write_out <= 1'b0;
            wdog_sel_out <= ~wdog_sel_out;
            cnt_q <= (en_in && reset_n_in) ? cnt_q + 8'h01 : 8'h00;
        end
    end
endmodule : msq_host_model

//--- sim/msq_sequencer_tb.sv
// Bench for the mode sequencer: power-up, undervoltage, wake paths.
// Assumes MS_CYC shortened to 8 and cyclic sense left off.
`timescale 1ns/10ps
module msq_sequencer_tb;
    localparam int MS = 8;
    localparam int TOL = 4;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic host_en = 1'b0;
    logic [1:0] host_sel = 2'h3;
    logic [7:0] host_gap = 8'h10;
    logic wdog_write;
    logic [1:0] wdog_sel;
    logic [2:0] cyc_sel = 3'h0;
    logic lp_enter = 1'b0;
    logic lp_sleep_sel = 1'b0;
    logic supply_loss = 1'b0;
    logic main_low = 1'b0;
    logic [3:0] wake = 4'h0;
    logic can_dom = 1'b0;
    msq_pkg::msq_pins_t pins;
    logic cmd_ready;
    msq_pkg::msq_state_t mode;
    int fail_count = 0;
    int num_checks = 0;
    int seed = 78872;
    int n;
    int dly;

    always #12.5 core_clk = ~core_clk;

    msq_sequencer #(.MS_CYC(MS), .NWAKE(4)) dut (
        .core_clk_in(core_clk), .arst_n_in(arst_n),
        .wdog_write_in(wdog_write), .wdog_sel_in(wdog_sel),
        .cyc_sel_in(cyc_sel), .cyc_sense_en_in(1'b0),
        .lp_enter_in(lp_enter), .lp_sleep_sel_in(lp_sleep_sel),
        .supply_loss_flag_in(supply_loss), .main_reg_low_in(main_low),
        .wake_input_in(wake), .can_dominant_in(can_dom),
        .pins_out(pins), .cmd_ready_out(cmd_ready), .mode_out(mode)
    );
    msq_host_model host (
        .clk_in(core_clk), .reset_n_in(pins.reset_n), .en_in(host_en),
        .sel_in(host_sel), .gap_in(host_gap),
        .wdog_write_out(wdog_write), .wdog_sel_out(wdog_sel)
    );

    // ==========================================================
    // Compare and wait tasks
    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test
    task automatic fail(input string msg);
        fail_count++;
        $display("[ERR] %0t %s", $time, msg);
    endtask : fail
    task automatic chk_pins(input logic [5:0] exp, input logic [5:0] mask);
        num_checks++;
        if ((6'(pins) & mask) !== exp)
            fail($sformatf("pins %h, expected %h", 6'(pins), exp));
    endtask : chk_pins
    task automatic chk_mode(input msq_pkg::msq_state_t exp);
        num_checks++;
        if (mode !== exp)
            fail($sformatf("mode %0d, expected %0d", mode, exp));
    endtask : chk_mode
    task automatic chk_bit(input logic exp);
        num_checks++;
        if (cmd_ready !== exp)
            fail("command ready wrong");
    endtask : chk_bit
    task automatic chk_dur(input int got, input int lo, input int hi);
        num_checks++;
        if (got < lo || got > hi)
            fail($sformatf("took %0d cycles, expected %0d..%0d", got, lo, hi));
    endtask : chk_dur
    task automatic cyc(input int k);
        repeat (k) @(negedge core_clk);
    endtask : cyc
    task automatic wait_mode(input msq_pkg::msq_state_t st, input int lim);
        n = 0;
        while (mode !== st && n < lim)
        begin
            cyc(1);
            n++;
        end
        chk_mode(st);
    endtask : wait_mode
    task automatic wait_pins(input logic [5:0] exp, input logic [5:0] mask, input int lim);
        n = 0;
        while ((6'(pins) & mask) !== exp && n < lim)
        begin
            cyc(1);
            n++;
        end
        chk_pins(exp, mask);
    endtask : wait_pins
    task automatic to_normal;
        host_en = 1'b1;
        wait_mode(msq_pkg::ST_NORMAL, 200);
        chk_pins(6'h3e, 6'h3e);
    endtask : to_normal
    task automatic pulse_lp(input logic sleep);
        lp_sleep_sel = sleep;
        lp_enter = 1'b1;
        cyc(1);
        lp_enter = 1'b0;
    endtask : pulse_lp
    task automatic wake_event(input int src, input msq_pkg::msq_state_t st);
        dly = (src == 0) ? msq_pkg::WAKE_DLY_CYC : msq_pkg::CAN_DLY_CYC;
        if (src == 0)
        begin
            wake = 4'h1 << ($random(seed) & 3);
            cyc(1);
            wake = 4'h0;
        end
        else
        begin
            for (int p = 0; p < 3; p++)
            begin
                cyc(2 + ($random(seed) & 7));
                if (p == 2)
                    chk_mode(st);
                can_dom = 1'b1;
                cyc(1);
                can_dom = 1'b0;
            end
        end
    endtask : wake_event

    // ==========================================================
    // Scenarios
    initial
    begin
        host_gap = 8'(5 + ($random(seed) & 31));
        cyc_sel = 3'($random(seed));
        cyc(4);
        chk_pins(6'h14, 6'h3f);
        chk_mode(msq_pkg::ST_NREQ);
        arst_n = 1'b1;
        cyc(3);
        chk_pins(6'h34, 6'h3f);
        chk_bit(1'b1);
        wait_mode(msq_pkg::ST_WDOG_RST, 3000);
        chk_dur(n + 3, 350 * MS - TOL, 350 * MS + TOL);
        chk_pins(6'h00, 6'h20);
        wait_mode(msq_pkg::ST_NREQ, 4100);
        chk_dur(n, msq_pkg::WDOG_RST_CYC - TOL, msq_pkg::WDOG_RST_CYC + TOL);
        $display("Test power-up done");
        for (int s = 0; s < 4; s++)
        begin
            host_sel = 2'(s);
            to_normal();
            cyc(100);
            chk_mode(msq_pkg::ST_NORMAL);
            host_en = 1'b0;
            dly = msq_pkg::WDOG_MS[s] * MS;
            wait_mode(msq_pkg::ST_WDOG_RST, 3000);
            chk_dur(n, dly - host_gap - TOL, dly + TOL);
            wait_mode(msq_pkg::ST_NREQ, 4100);
        end
        $display("Test watchdog periods done");
        for (int f = 0; f < 2; f++)
        begin
            to_normal();
            lp_sleep_sel = f[0];
            supply_loss = f[0];
            main_low = 1'b1;
            wait_mode(msq_pkg::ST_UV_RST, 3);
            chk_pins(6'h08, 6'h38);
            cyc(50);
            chk_mode(msq_pkg::ST_UV_RST);
            main_low = 1'b0;
            wait_mode(msq_pkg::ST_NREQ, 3);
        end
        to_normal();
        lp_sleep_sel = 1'b1;
        supply_loss = 1'b0;
        main_low = 1'b1;
        wait_mode(msq_pkg::ST_UV_HOLD, 3);
        chk_pins(6'h00, 6'h30);
        host_en = 1'b0;
        wait_mode(msq_pkg::ST_SLEEP, 900);
        chk_dur(n, 100 * MS - TOL, 100 * MS + TOL);
        chk_pins(6'h00, 6'h07);
        $display("Test undervoltage done");
        for (int src = 0; src < 2; src++)
        begin
            if (src == 1)
            begin
                to_normal();
                pulse_lp(1'b1);
                wait_mode(msq_pkg::ST_SLEEP, 3);
                host_en = 1'b0;
                main_low = 1'b1;
            end
            wake_event(src, msq_pkg::ST_SLEEP);
            wait_pins(6'h04, 6'h04, 4100);
            chk_dur(n, dly - TOL, dly + TOL);
            cyc(20);
            main_low = 1'b0;
            cyc(2);
            chk_pins(6'h00, 6'h20);
            wait_mode(msq_pkg::ST_NREQ, 60);
            chk_dur(n + 2, 4 * MS - TOL, 4 * MS + TOL);
            chk_pins(6'h20, 6'h20);
        end
        $display("Test sleep wake done");
        for (int src = 0; src < 2; src++)
        begin
            to_normal();
            pulse_lp(1'b0);
            wait_mode(msq_pkg::ST_STOP, 3);
            wake_event(src, msq_pkg::ST_STOP);
            wait_pins(6'h00, 6'h10, 4100);
            chk_dur(n, dly - TOL, dly + TOL);
            wait_pins(6'h10, 6'h10, 500);
            chk_dur(n, msq_pkg::INT_PULSE_CYC - TOL, msq_pkg::INT_PULSE_CYC + TOL);
            chk_bit(1'b0);
            wait_mode(msq_pkg::ST_NORMAL, 1400);
            chk_dur(n, msq_pkg::CMD_DLY_CYC - TOL, msq_pkg::CMD_DLY_CYC + TOL);
            chk_bit(1'b1);
        end
        $display("Test stop wake done");
        end_of_test();
    end

    initial
    begin
        repeat (90000) @(posedge core_clk);
        fail("watchdog expired");
        end_of_test();
    end
endmodule : msq_sequencer_tb
